// >>> rtl/piu_pkg.sv
// Shared types and constants of the port I/O instruction unit
package piu_pkg;

  localparam int NIB_W = 4;
  localparam int PORTD_W = 8;
  localparam int IDX_W = 3;
  localparam int RADDR_W = 4;
  localparam int RDATA_W = 8;

  // Highest bit-addressable port bit that the bit test accepts
  localparam logic [IDX_W-1:0] TEST_IDX_MAX = 3'h5;

  // Values after reset
  localparam logic [NIB_W-1:0] CFG_RST = 4'h0;
  localparam logic LATCH_RST_BIT = 1'b1;
  localparam logic PORTC_RST = 1'b1;

  // Index of each control register in the configuration array
  localparam int CFG_N = 8;
  localparam logic [2:0] CFG_PULLUP0 = 3'h0;
  localparam logic [2:0] CFG_PULLUP1 = 3'h1;
  localparam logic [2:0] CFG_WAKE0 = 3'h2;
  localparam logic [2:0] CFG_WAKE1 = 3'h3;
  localparam logic [2:0] CFG_WAKE2 = 3'h4;
  localparam logic [2:0] CFG_OSTRUCT0 = 3'h5;
  localparam logic [2:0] CFG_OSTRUCT1 = 3'h6;
  localparam logic [2:0] CFG_OSTRUCT2 = 3'h7;

  // Register port offsets: 0x0 to 0x7 are the configuration array
  localparam logic [RADDR_W-1:0] REG_CFG_LAST = 4'h7;
  localparam logic [RADDR_W-1:0] REG_PORT0_LATCH = 4'h8;
  localparam logic [RADDR_W-1:0] REG_PORT1_LATCH = 4'h9;
  localparam logic [RADDR_W-1:0] REG_PORT2_LATCH = 4'ha;
  localparam logic [RADDR_W-1:0] REG_PD_LATCH = 4'hb;
  localparam logic [RADDR_W-1:0] REG_PC_LATCH = 4'hc;
  localparam logic [RADDR_W-1:0] REG_PIN01 = 4'hd;
  localparam logic [RADDR_W-1:0] REG_PIN2 = 4'he;
  localparam logic [RADDR_W-1:0] REG_STATUS = 4'hf;
  localparam int STAT_SKIP = 0;
  localparam int STAT_BADIDX = 1;

  typedef enum logic [4:0] {
    OP_NONE, OP_IN_PORT0, OP_OUT_PORT0, OP_IN_PORT1, OP_OUT_PORT1, OP_IN_PORT2,
    OP_OUT_PORT2, OP_SET_ALL_D, OP_CLR_D, OP_SET_D, OP_TEST_D, OP_CLR_C, OP_SET_C,
    OP_RD_PULLUP0, OP_WR_PULLUP0, OP_RD_PULLUP1, OP_WR_PULLUP1,
    OP_RD_WAKE0, OP_WR_WAKE0, OP_RD_WAKE1, OP_WR_WAKE1, OP_RD_WAKE2, OP_WR_WAKE2,
    OP_WR_OSTRUCT0, OP_WR_OSTRUCT1, OP_WR_OSTRUCT2
  } piu_op_t;

  typedef struct packed {
    logic valid;
    piu_op_t op;
    logic [NIB_W-1:0] acc;
    logic [IDX_W-1:0] idx;
  } piu_instr_t;

  typedef struct packed {
    logic acc_we;
    logic [NIB_W-1:0] acc_val;
    logic skip;
    logic carry_we;
  } piu_result_t;

endpackage

// >>> rtl/piu_pin_cell.sv
// Output latch with pin drive for one group of port bits
`timescale 1ns/1ps
module piu_pin_cell
  import piu_pkg::*;
#(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Latch update
  input wire logic ld_i,
  input wire logic [W-1:0] ld_val_i,
  input wire logic [W-1:0] push_pull_i,
  // Latch and pin drive
  output logic [W-1:0] latch_o,
  output logic [W-1:0] pin_out_o,
  output logic [W-1:0] pin_oe_o
);

  logic [W-1:0] latch_ff;
  logic [W-1:0] nxt_latch;
  logic [W-1:0] out_ff;
  logic [W-1:0] oe_ff;

  assign nxt_latch = ld_i ? ld_val_i : latch_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_ff <= {W{LATCH_RST_BIT}};
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // Open-drain bits only pull low; a 1 releases the pin so it can be read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff <= '0;
      oe_ff <= '0;
    end else begin
      out_ff <= nxt_latch & push_pull_i;
      oe_ff <= push_pull_i | ~nxt_latch;
    end
  end

  assign latch_o = latch_ff;
  assign pin_out_o = out_ff;
  assign pin_oe_o = oe_ff;

endmodule

// >>> rtl/piu_port_unit.sv
// Port and pin-control instruction execution unit
`timescale 1ns/1ps
module piu_port_unit
  import piu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Instruction sequencer
  input wire piu_instr_t instr_i,
  output piu_result_t res_o,
  // Parallel I/O ports
  input wire logic [NIB_W-1:0] port0_in_i,
  output logic [NIB_W-1:0] port0_out_o,
  output logic [NIB_W-1:0] port0_oe_o,
  input wire logic [NIB_W-1:0] port1_in_i,
  output logic [NIB_W-1:0] port1_out_o,
  output logic [NIB_W-1:0] port1_oe_o,
  input wire logic [NIB_W-1:0] port2_in_i,
  output logic [NIB_W-1:0] port2_out_o,
  output logic [NIB_W-1:0] port2_oe_o,
  // Output-only ports
  output logic [PORTD_W-1:0] portd_o,
  output logic portc_o,
  // Pin control levels
  output logic [NIB_W-1:0] pullup0_o,
  output logic [NIB_W-1:0] pullup1_o,
  output logic [NIB_W-1:0] wakeup0_o,
  output logic [NIB_W-1:0] wakeup1_o,
  output logic [NIB_W-1:0] wakeup2_o,
  // Register port
  input wire logic [RADDR_W-1:0] addr_i,
  input wire logic [RDATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [RDATA_W-1:0] rdata_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  logic exec;
  piu_op_t op;
  logic [NIB_W-1:0] acc;
  logic [IDX_W-1:0] idx;

  assign exec = instr_i.valid;
  assign op = instr_i.op;
  assign acc = instr_i.acc;
  assign idx = instr_i.idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers: pull-up, key-on wakeup and output structure

  logic [NIB_W-1:0] cfg_ff [CFG_N];
  logic cfg_ld;
  logic [2:0] cfg_sel;

  always_comb begin
    cfg_ld = exec;
    cfg_sel = CFG_PULLUP0;
    case (op)
      OP_WR_PULLUP0: cfg_sel = CFG_PULLUP0;
      OP_WR_PULLUP1: cfg_sel = CFG_PULLUP1;
      OP_WR_WAKE0: cfg_sel = CFG_WAKE0;
      OP_WR_WAKE1: cfg_sel = CFG_WAKE1;
      OP_WR_WAKE2: cfg_sel = CFG_WAKE2;
      OP_WR_OSTRUCT0: cfg_sel = CFG_OSTRUCT0;
      OP_WR_OSTRUCT1: cfg_sel = CFG_OSTRUCT1;
      OP_WR_OSTRUCT2: cfg_sel = CFG_OSTRUCT2;
      default: cfg_ld = 1'b0;
    endcase
  end

  // An instruction write beats a software write to the same register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CFG_N; i++) begin
        cfg_ff[i] <= CFG_RST;
      end
    end else begin
      if (wr_i && addr_i <= REG_CFG_LAST) begin
        cfg_ff[addr_i[2:0]] <= wdata_i[NIB_W-1:0];
      end
      if (cfg_ld) begin
        cfg_ff[cfg_sel] <= acc;
      end
    end
  end

  assign pullup0_o = cfg_ff[CFG_PULLUP0];
  assign pullup1_o = cfg_ff[CFG_PULLUP1];
  assign wakeup0_o = cfg_ff[CFG_WAKE0];
  assign wakeup1_o = cfg_ff[CFG_WAKE1];
  assign wakeup2_o = cfg_ff[CFG_WAKE2];

  ////////////////////////////////////////////////////////////////////////////////
  // Port latches

  logic [NIB_W-1:0] port0_latch;
  logic [NIB_W-1:0] port1_latch;
  logic [NIB_W-1:0] port2_latch;
  logic [PORTD_W-1:0] pd_latch;
  logic [0:0] pc_latch;
  logic [PORTD_W-1:0] nxt_pd;
  logic pd_ld;
  logic [0:0] nxt_pc;
  logic pc_ld;

  // Output-structure bit 1 means push-pull, 0 means open drain
  piu_pin_cell #(.W(NIB_W)) u_port0 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ld_i(exec && op == OP_OUT_PORT0),
    .ld_val_i(acc),
    .push_pull_i(cfg_ff[CFG_OSTRUCT0]),
    .latch_o(port0_latch),
    .pin_out_o(port0_out_o),
    .pin_oe_o(port0_oe_o)
  );

  piu_pin_cell #(.W(NIB_W)) u_port1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ld_i(exec && op == OP_OUT_PORT1),
    .ld_val_i(acc),
    .push_pull_i(cfg_ff[CFG_OSTRUCT1]),
    .latch_o(port1_latch),
    .pin_out_o(port1_out_o),
    .pin_oe_o(port1_oe_o)
  );

  piu_pin_cell #(.W(NIB_W)) u_port2 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ld_i(exec && op == OP_OUT_PORT2),
    .ld_val_i(acc),
    .push_pull_i(cfg_ff[CFG_OSTRUCT2]),
    .latch_o(port2_latch),
    .pin_out_o(port2_out_o),
    .pin_oe_o(port2_oe_o)
  );

  always_comb begin
    nxt_pd = pd_latch;
    pd_ld = exec;
    case (op)
      OP_SET_ALL_D: nxt_pd = '1;
      OP_CLR_D: nxt_pd[idx] = 1'b0;
      OP_SET_D: nxt_pd[idx] = 1'b1;
      default: pd_ld = 1'b0;
    endcase
  end

  // Bit port is output only, so it always drives
  piu_pin_cell #(.W(PORTD_W)) u_portd (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ld_i(pd_ld),
    .ld_val_i(nxt_pd),
    .push_pull_i('1),
    .latch_o(pd_latch),
    .pin_out_o(portd_o),
    .pin_oe_o()
  );

  assign pc_ld = exec && (op == OP_CLR_C || op == OP_SET_C);
  assign nxt_pc = (op == OP_SET_C) ? 1'b1 : 1'b0;

  piu_pin_cell #(.W(1)) u_portc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ld_i(pc_ld),
    .ld_val_i(nxt_pc),
    .push_pull_i(1'b1),
    .latch_o(pc_latch),
    .pin_out_o(portc_o),
    .pin_oe_o()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Accumulator result, skip and carry

  piu_result_t res_ff;
  piu_result_t nxt_res;
  logic test_ok;

  // Indices 6 and 7 are outside the tested range and never skip
  assign test_ok = idx <= TEST_IDX_MAX;

  always_comb begin
    nxt_res = '0;
    if (exec) begin
      nxt_res.acc_we = 1'b1;
      case (op)
        OP_IN_PORT0: nxt_res.acc_val = port0_in_i;
        OP_IN_PORT1: nxt_res.acc_val = port1_in_i;
        OP_IN_PORT2: nxt_res.acc_val = port2_in_i;
        OP_RD_PULLUP0: nxt_res.acc_val = cfg_ff[CFG_PULLUP0];
        OP_RD_PULLUP1: nxt_res.acc_val = cfg_ff[CFG_PULLUP1];
        OP_RD_WAKE0: nxt_res.acc_val = cfg_ff[CFG_WAKE0];
        OP_RD_WAKE1: nxt_res.acc_val = cfg_ff[CFG_WAKE1];
        OP_RD_WAKE2: nxt_res.acc_val = cfg_ff[CFG_WAKE2];
        default: nxt_res.acc_we = 1'b0;
      endcase
      nxt_res.skip = (op == OP_TEST_D) && test_ok && !pd_latch[idx];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_ff <= '0;
    end else begin
      res_ff <= nxt_res;
    end
  end

  assign res_o = res_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Status and register read port

  logic stat_skip_ff;
  logic stat_badidx_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_skip_ff <= 1'b0;
      stat_badidx_ff <= 1'b0;
    end else if (exec && op == OP_TEST_D) begin
      stat_skip_ff <= nxt_res.skip;
      stat_badidx_ff <= !test_ok;
    end
  end

  logic [RDATA_W-1:0] rdata_ff;
  logic [RDATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    case (addr_i)
      REG_PORT0_LATCH: nxt_rdata = {4'h0, port0_latch};
      REG_PORT1_LATCH: nxt_rdata = {4'h0, port1_latch};
      REG_PORT2_LATCH: nxt_rdata = {4'h0, port2_latch};
      REG_PD_LATCH: nxt_rdata = pd_latch;
      REG_PC_LATCH: nxt_rdata = {7'h00, pc_latch};
      REG_PIN01: nxt_rdata = {port1_in_i, port0_in_i};
      REG_PIN2: nxt_rdata = {4'h0, port2_in_i};
      REG_STATUS: begin
        nxt_rdata[STAT_SKIP] = stat_skip_ff;
        nxt_rdata[STAT_BADIDX] = stat_badidx_ff;
      end
      default: nxt_rdata = {4'h0, cfg_ff[addr_i[2:0]]};
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= rd_i ? nxt_rdata : '0;
    end
  end

  assign rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_in_port0;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_IN_PORT0 |=> res_o.acc_we && res_o.acc_val == $past(port0_in_i);
  endproperty
  a_in_port0: assert property (p_in_port0) else $error("port0 read wrong");
  // Pins follow the latch in the same cycle and the structure setting one edge before them
  property p_out_port0;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_OUT_PORT0 |=> port0_latch == $past(acc) ##1
        port0_out_o == (port0_latch & $past(cfg_ff[CFG_OSTRUCT0]));
  endproperty
  a_out_port0: assert property (p_out_port0) else $error("port0 write wrong");
  property p_in_port1;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_IN_PORT1 |=> res_o.acc_we && res_o.acc_val == $past(port1_in_i);
  endproperty
  a_in_port1: assert property (p_in_port1) else $error("port1 read wrong");
  property p_out_port2;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_OUT_PORT2 |=> port2_latch == $past(acc);
  endproperty
  a_out_port2: assert property (p_out_port2) else $error("port2 write wrong");
  property p_set_all;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_SET_ALL_D |=> portd_o == 8'hff;
  endproperty
  a_set_all: assert property (p_set_all) else $error("set all failed");
  property p_clr_bit;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_CLR_D |=> pd_latch == ($past(pd_latch) & ~(8'h01 << $past(idx)));
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("bit clear wrong");
  property p_set_bit;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_SET_D |=> pd_latch == ($past(pd_latch) | (8'h01 << $past(idx)));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");
  property p_test;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_TEST_D |=>
        res_o.skip == ($past(idx) <= TEST_IDX_MAX && !$past(pd_latch[idx]));
  endproperty
  a_test: assert property (p_test) else $error("bit test skip wrong");
  property p_portc;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op inside {OP_CLR_C, OP_SET_C} |=> portc_o == $past(op == OP_SET_C);
  endproperty
  a_portc: assert property (p_portc) else $error("one-bit port wrong");
  property p_pullup0;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_WR_PULLUP0 ##1 exec && op == OP_RD_PULLUP0 |=>
        res_o.acc_val == $past(acc, 2);
  endproperty
  a_pullup0: assert property (p_pullup0) else $error("pull-up readback wrong");
  property p_wake2;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_WR_WAKE2 |=> wakeup2_o == $past(acc);
  endproperty
  a_wake2: assert property (p_wake2) else $error("wakeup write wrong");
  property p_ostruct1;
    @(posedge clk_i) disable iff (!rst_n_i)
      exec && op == OP_WR_OSTRUCT1 |=> cfg_ff[CFG_OSTRUCT1] == $past(acc);
  endproperty
  a_ostruct1: assert property (p_ostruct1) else $error("output structure write wrong");
  property p_no_skip;
    @(posedge clk_i) disable iff (!rst_n_i)
      res_o.skip |-> $past(op) == OP_TEST_D && !res_o.carry_we;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("unexpected skip");

  c_skip: cover property (@(posedge clk_i) disable iff (!rst_n_i) res_o.skip);
  c_od_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    exec && op == OP_IN_PORT1 && cfg_ff[CFG_OSTRUCT1] == 4'h0);
  c_clr_set: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    exec && op == OP_CLR_D ##1 exec && op == OP_SET_D);
  c_sw_cfg: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_i && cfg_ld);

endmodule

// >>> testbench/piu_pin_model.sv
// External pin model for the three parallel ports of the port I/O unit
`timescale 1ns/1ps
module piu_pin_model (
  // Design drive
  input wire logic [11:0] out_i,
  input wire logic [11:0] oe_i,
  // External drive
  input wire logic [11:0] drv_i,
  input wire logic [11:0] ext_i,
  // Resolved pin levels
  output logic [11:0] lvl_o
);
  // A pin nobody drives floats high through its pull-up, never to a stale value
  always_comb begin
    for (int b = 0; b < 12; b++) begin
      lvl_o[b] = oe_i[b] ? out_i[b] : (drv_i[b] ? ext_i[b] : 1'b1);
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking testbench of the port I/O instruction unit
`timescale 1ns/1ps
module tb_top;
  import piu_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic wr_i;
  logic rd_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic [7:0] portd_o;
  logic portc_o;
  logic [3:0] v;
  logic [11:0] drv;
  logic [11:0] ext;
  wire logic [11:0] pout;
  wire logic [11:0] poe;
  wire logic [11:0] lvl;
  wire logic [19:0] ctl;
  piu_instr_t instr_i;
  piu_result_t res_o;
  piu_result_t r;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  piu_op_t out_op[3] = '{OP_OUT_PORT0, OP_OUT_PORT1, OP_OUT_PORT2};
  piu_op_t in_op[3] = '{OP_IN_PORT0, OP_IN_PORT1, OP_IN_PORT2};
  piu_op_t fr_op[3] = '{OP_WR_OSTRUCT0, OP_WR_OSTRUCT1, OP_WR_OSTRUCT2};
  piu_op_t cw_op[5] = '{OP_WR_PULLUP0, OP_WR_PULLUP1, OP_WR_WAKE0, OP_WR_WAKE1, OP_WR_WAKE2};
  piu_op_t cr_op[5] = '{OP_RD_PULLUP0, OP_RD_PULLUP1, OP_RD_WAKE0, OP_RD_WAKE1, OP_RD_WAKE2};

  ////////////////////////////////////////////////////////////////////////////
  piu_port_unit piu_port_unit_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .res_o(res_o),
    .port0_in_i(lvl[3:0]), .port0_out_o(pout[3:0]), .port0_oe_o(poe[3:0]),
    .port1_in_i(lvl[7:4]), .port1_out_o(pout[7:4]), .port1_oe_o(poe[7:4]),
    .port2_in_i(lvl[11:8]), .port2_out_o(pout[11:8]), .port2_oe_o(poe[11:8]),
    .portd_o(portd_o), .portc_o(portc_o),
    .pullup0_o(ctl[3:0]), .pullup1_o(ctl[7:4]), .wakeup0_o(ctl[11:8]),
    .wakeup1_o(ctl[15:12]), .wakeup2_o(ctl[19:16]),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o)
  );
  piu_pin_model piu_pin_model_inst (
    .out_i(pout), .oe_i(poe), .drv_i(drv), .ext_i(ext), .lvl_o(lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task step;
    @(posedge clk_i);
    #1;
  endtask

  task ins(input piu_op_t op, input logic [3:0] a, input logic [2:0] x);
    @(posedge clk_i);
    instr_i <= '{valid: 1'b1, op: op, acc: a, idx: x};
    @(posedge clk_i);
    instr_i.valid <= 1'b0;
    #1 r = res_o;
    chk({7'h0, r.carry_we}, 8'h00);
    if (op != OP_TEST_D) chk({7'h0, r.skip}, 8'h00);
  endtask

  // Two instructions on consecutive edges; r holds the second result
  task ins2(input piu_op_t op_a, input logic [3:0] a_a, input piu_op_t op_b,
            input logic [3:0] a_b, input logic [2:0] x);
    @(posedge clk_i);
    instr_i <= '{valid: 1'b1, op: op_a, acc: a_a, idx: x};
    @(posedge clk_i);
    instr_i <= '{valid: 1'b1, op: op_b, acc: a_b, idx: x};
    @(posedge clk_i);
    instr_i.valid <= 1'b0;
    #1 r = res_o;
  endtask

  task reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask

  task end_sim;
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    instr_i = '0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    // Bits 0 and 1 of every port are pulled low from outside when released
    drv = 12'h333;
    ext = 12'h000;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) reg_rd(4'(i), 8'h00);
    chk(portd_o, 8'hff);
    chk({7'h0, portc_o}, 8'h01);
    for (int n = 0; n < 3; n++) begin
      v = 4'h6 + 4'(n);
      ins(fr_op[n], 4'hf, 3'h0);
      reg_rd(4'(5 + n), 8'h0f);
      ins(out_op[n], v, 3'h0);
      reg_rd(4'(8 + n), {4'h0, v});
      chk({4'h0, pout[n*4 +: 4]}, {4'h0, v});
      chk({4'h0, poe[n*4 +: 4]}, 8'h0f);
      ins(fr_op[n], 4'h0, 3'h0);
      ins(out_op[n], v, 3'h0);
      ins(in_op[n], 4'h0, 3'h0);
      chk({3'h0, r.acc_we, r.acc_val}, {4'h1, v & 4'hc});
      chk({4'h0, poe[n*4 +: 4]}, {4'h0, ~v});
    end
    ins(OP_CLR_D, 4'h0, 3'h2);
    ins(OP_CLR_D, 4'h0, 3'h7);
    ins(OP_SET_ALL_D, 4'h0, 3'h0);
    step;
    chk(portd_o, 8'hff);
    for (int i = 0; i < 8; i++) begin
      ins(OP_CLR_D, 4'h0, 3'(i));
      step;
      chk(portd_o, ~(8'h01 << i));
      ins(OP_TEST_D, 4'h0, 3'(i));
      chk({7'h0, r.skip}, {7'h0, 1'(i <= 5)});
      reg_rd(4'hf, (i <= 5) ? 8'h01 : 8'h02);
      ins(OP_SET_D, 4'h0, 3'(i));
      step;
      chk(portd_o, 8'hff);
      ins(OP_TEST_D, 4'h0, 3'(i));
      chk({7'h0, r.skip}, 8'h00);
    end
    ins(OP_CLR_C, 4'h0, 3'h0);
    step;
    chk({7'h0, portc_o}, 8'h00);
    ins(OP_SET_C, 4'h0, 3'h0);
    step;
    chk({7'h0, portc_o}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      v = 4'h9 - 4'(i);
      ins(cw_op[i], v, 3'h0);
      ins(cr_op[i], 4'h0, 3'h0);
      chk({3'h0, r.acc_we, r.acc_val}, {4'h1, v});
      reg_rd(4'(i), {4'h0, v});
      chk({4'h0, ctl[i*4 +: 4]}, {4'h0, v});
    end
    ins2(OP_WR_PULLUP0, 4'h3, OP_RD_PULLUP0, 4'h0, 3'h0);
    chk({3'h0, r.acc_we, r.acc_val}, 8'h13);
    ins2(OP_CLR_D, 4'h0, OP_SET_D, 4'h0, 3'h3);
    step;
    chk(portd_o, 8'hff);
    // Software side: upper bits read zero and the latch window is read-only
    reg_wr(4'h6, 8'h5a);
    reg_rd(4'h6, 8'h0a);
    reg_wr(4'h8, 8'h00);
    reg_rd(4'h8, 8'h06);
    reg_rd(4'hb, 8'hff);
    // Port1 now mixes push-pull bits 1 and 3 with released bits 0 and 2
    reg_rd(4'hd, 8'h64);
    reg_rd(4'he, 8'h08);
    end_sim();
  end
endmodule
